// ### tamal_pkg.sv
// Shared constants and types for the two-address memory access and resistor look-up block.
// Assumes one 100 MHz clock and a two-wire bus host that keeps to standard bus timing.
// Operation
// - Temperature maps to look-up address 80h at -40 or colder, C7h at +102 up.
// - Each look-up entry holds an independent full-byte position for each resistor.
// - Clearing the temperature-index enable switches both resistors to manual positions.
// - Manual mode takes resistor 0 from table-one 82h and resistor 1 from 83h.
// - Supply voltage is an unsigned 16-bit word, 100 microvolts per step.
// - Each analog monitor is an unsigned 16-bit word, 38.147 microvolts per step.
// - Temperature is two's complement; signed whole degrees high, 1/256 degree low.
// - Single-address bit clear: answer auxiliary A0h and main A2h addresses.
// - Address-from-memory bit set: main address comes from table-one byte 8Ch.
// - The stored main address resets to A2h.
// - Single-address bit set: auxiliary ignored, table zero reachable through main address.
// - Locations 80h and up are reachable only through the main address.
// - Main byte 7Fh selects the upper table; auxiliary memory is one choice.
// - Main memory is write protected only when protect pin and bit are high.
// - Auxiliary memory and table zero are protected whenever the auxiliary bit is set.
// - Programmable main address lets up to 128 devices share one bus.
// - Protect pin idles high; grounding it disables pin-based protection.
package tamal_pkg;

   // Bus addresses
   localparam logic [7:0] TAMAL_AUX_ADDR       = 8'hA0;
   localparam logic [7:0] TAMAL_MAIN_ADDR      = 8'hA2;
   localparam logic [7:0] TAMAL_NVM_ADDR_RESET = 8'hA2;

   // Main lower map
   localparam logic [7:0] TAMAL_OFS_MEAS_LO = 8'h60;
   localparam logic [7:0] TAMAL_OFS_MEAS_HI = 8'h6F;
   localparam logic [7:0] TAMAL_OFS_TABLE_SEL = 8'h7F;
   localparam logic [7:0] TAMAL_OFS_UPPER   = 8'h80;

   // Table one locations held in flops
   localparam logic [7:0] TAMAL_OFS_MANUAL_ZERO = 8'h82;
   localparam logic [7:0] TAMAL_OFS_MANUAL_ONE  = 8'h83;
   localparam logic [7:0] TAMAL_OFS_CONFIG      = 8'h89;
   localparam logic [7:0] TAMAL_OFS_STORED_ADDR = 8'h8C;

   // Config byte fields
   localparam int TAMAL_CFG_TEMP_INDEX  = 0;
   localparam int TAMAL_CFG_SINGLE_ADDR = 1;
   localparam int TAMAL_CFG_ADDR_NVM    = 2;
   localparam int TAMAL_CFG_MAIN_PROT   = 3;
   localparam int TAMAL_CFG_AUX_PROT    = 4;
   localparam logic [7:0] TAMAL_CFG_RESET = 8'h01;

   // Table selector values
   localparam logic [7:0] TAMAL_SEL_TABLE0 = 8'h00;
   localparam logic [7:0] TAMAL_SEL_TABLE1 = 8'h01;
   localparam logic [7:0] TAMAL_SEL_LUT0   = 8'h02;
   localparam logic [7:0] TAMAL_SEL_LUT1   = 8'h03;
   localparam logic [7:0] TAMAL_SEL_AUX    = 8'h04;
   localparam logic [7:0] TAMAL_SEL_RESET  = 8'h00;

   // Memory blocks of 128 bytes
   localparam int         TAMAL_MEM_AW     = 10;
   localparam logic [2:0] TAMAL_BLK_MAIN   = 3'h0;
   localparam logic [2:0] TAMAL_BLK_AUX    = 3'h1;
   localparam logic [2:0] TAMAL_BLK_TABLE0 = 3'h2;
   localparam logic [2:0] TAMAL_BLK_TABLE1 = 3'h3;
   localparam logic [2:0] TAMAL_BLK_LUT0   = 3'h4;
   localparam logic [2:0] TAMAL_BLK_LUT1   = 3'h5;

   // Look-up index range
   localparam logic signed [8:0] TAMAL_TEMP_MIN  = -9'sd40;
   localparam logic signed [8:0] TAMAL_TEMP_MAX  = 9'sd102;
   localparam logic [6:0]        TAMAL_INDEX_MAX = 7'h47;

   localparam logic [7:0] TAMAL_UNMAPPED_READ = 8'hFF;
   localparam logic [3:0] TAMAL_BITS_PER_BYTE = 4'h8;

   typedef enum logic [2:0] {
      TAMAL_IDLE  = 3'b000,
      TAMAL_DEV   = 3'b001,
      TAMAL_WADDR = 3'b010,
      TAMAL_WDATA = 3'b011,
      TAMAL_ACK   = 3'b100,
      TAMAL_RD    = 3'b101,
      TAMAL_RACK  = 3'b110,
      TAMAL_RLOAD = 3'b111
   } tamal_state_t;

   typedef enum logic [1:0] {
      TAMAL_K_NONE = 2'b00,
      TAMAL_K_MEM  = 2'b01,
      TAMAL_K_MEAS = 2'b10,
      TAMAL_K_FLOP = 2'b11
   } tamal_kind_t;

   // Measured words from the converter, same clock
   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] vcc;
      logic [15:0] mon_a;
      logic [15:0] mon_b;
      logic [15:0] mon_c;
   } tamal_meas_t;

   typedef struct packed {
      logic [7:0] zero;
      logic [7:0] one;
   } tamal_pos_t;

   typedef struct packed {
      logic [2:0]   scl_s;
      logic [2:0]   sda_s;
      logic [2:0]   prot_s;
      logic         scl_f;
      logic         sda_f;
      logic         prot_f;
      tamal_state_t state;
      tamal_state_t after;
      logic [3:0]   bitcnt;
      logic [7:0]   shift;
      logic         dev_main;
      logic [7:0]   ptr;
      logic [7:0]   selector;
      logic [7:0]   manual_zero;
      logic [7:0]   manual_one;
      logic [7:0]   cfg;
      logic [7:0]   nvm_addr;
      logic         sda_oe;
      logic         we;
      logic [9:0]   waddr;
      logic [7:0]   wdata;
      logic         lut_phase;
      logic         lut_phase_d;
      logic [7:0]   lut_zero;
      logic [7:0]   lut_one;
      tamal_pos_t   pos;
      logic         manual;
   } tamal_regs_t;

endpackage : tamal_pkg

// ### tamal_byte_mem.sv
// Byte memory: one write port, two registered read ports.
// Contents are not reset; the bus and the look-up read it independently.
`timescale 1ns/1ps
`default_nettype none
module tamal_byte_mem #(
   parameter int AW = 10
) (
   // Clock
   input  wire logic          clk_in,
   // Write port
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in,
   // Read ports
   input  wire logic [AW-1:0] raddr_a_in,
   output logic      [7:0]    rdata_a_out,
   input  wire logic [AW-1:0] raddr_b_in,
   output logic      [7:0]    rdata_b_out
);

   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      rdata_a_out <= mem[raddr_a_in];
      rdata_b_out <= mem[raddr_b_in];
   end

endmodule : tamal_byte_mem
`default_nettype wire

// ### tamal_temp_index.sv
// Temperature whole degrees to look-up entry index, two degrees per entry.
// Pure combinational; the caller registers the result path.
`timescale 1ns/1ps
`default_nettype none
module tamal_temp_index
   import tamal_pkg::*;
(
   // Signed whole degrees
   input  wire logic [7:0] whole_in,
   // Entry index 0 to 71
   output logic      [6:0] index_out
);

   logic signed [8:0] whole;
   logic signed [8:0] offset;

   always_comb begin
      whole  = signed'({whole_in[7], whole_in});
      offset = whole - TAMAL_TEMP_MIN;
      if (whole < TAMAL_TEMP_MIN) begin
         index_out = 7'h00;
      end else if (whole >= TAMAL_TEMP_MAX) begin
         index_out = TAMAL_INDEX_MAX;
      end else begin
         index_out = offset[7:1];
      end
   end

endmodule : tamal_temp_index
`default_nettype wire

// ### tamal_access_top.sv
// Two-wire bus slave with two device addresses, table selection, write protection
// and the temperature look-up that drives two resistor positions.
// Assumes scl/sda/protect pins are asynchronous; measurement words share the clock.
`timescale 1ns/1ps
`default_nettype none
module tamal_access_top
   import tamal_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Two-wire bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_out,
   // Protect pin
   input  wire logic        protect_pin_in,
   // Converter results
   input  wire tamal_meas_t meas_in,
   // Resistor positions
   output tamal_pos_t       pos_out,
   output logic             manual_mode_out
);

   tamal_regs_t r_ff;
   tamal_regs_t nxt_r;

   logic [9:0]  mem_raddr_a;
   logic [9:0]  mem_raddr_b;
   logic [7:0]  mem_rdata_a;
   logic [7:0]  mem_rdata_b;
   logic [6:0]  lut_index;

   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic        temp_index_enable;
   logic        single_address_select;
   logic        main_address_from_nvm;
   logic        main_protect_bit;
   logic        aux_protect_bit;
   logic        main_locked;
   logic        aux_locked;
   logic [7:0]  main_addr;
   tamal_kind_t kind;
   logic [2:0]  blk;
   logic        locked;
   logic [7:0]  rd_val;
   logic [15:0] meas_word;
   logic        match_aux;
   logic        match_main;

   tamal_byte_mem #(
      .AW (TAMAL_MEM_AW)
   ) u_mem (
      .clk_in      (clk_in),
      .we_in       (r_ff.we),
      .waddr_in    (r_ff.waddr),
      .wdata_in    (r_ff.wdata),
      .raddr_a_in  (mem_raddr_a),
      .rdata_a_out (mem_rdata_a),
      .raddr_b_in  (mem_raddr_b),
      .rdata_b_out (mem_rdata_b)
   );

   // Whole degrees are the high byte of the temperature word
   tamal_temp_index u_index (
      .whole_in  (meas_in.temp[15:8]),
      .index_out (lut_index)
   );

   always_comb begin
      nxt_r = r_ff;
      nxt_r.we = 1'b0;

      // First flop feeds only the second
      nxt_r.scl_s  = {r_ff.scl_s[1:0], scl_in};
      nxt_r.sda_s  = {r_ff.sda_s[1:0], sda_in};
      nxt_r.prot_s = {r_ff.prot_s[1:0], protect_pin_in};
      if (r_ff.scl_s[1] == r_ff.scl_s[2]) begin
         nxt_r.scl_f = r_ff.scl_s[2];
      end
      if (r_ff.sda_s[1] == r_ff.sda_s[2]) begin
         nxt_r.sda_f = r_ff.sda_s[2];
      end
      if (r_ff.prot_s[1] == r_ff.prot_s[2]) begin
         nxt_r.prot_f = r_ff.prot_s[2];
      end

      scl_rise  = nxt_r.scl_f & ~r_ff.scl_f;
      scl_fall  = ~nxt_r.scl_f & r_ff.scl_f;
      bus_start = r_ff.scl_f & nxt_r.scl_f & r_ff.sda_f & ~nxt_r.sda_f;
      bus_stop  = r_ff.scl_f & nxt_r.scl_f & ~r_ff.sda_f & nxt_r.sda_f;

      temp_index_enable     = r_ff.cfg[TAMAL_CFG_TEMP_INDEX];
      single_address_select = r_ff.cfg[TAMAL_CFG_SINGLE_ADDR];
      main_address_from_nvm = r_ff.cfg[TAMAL_CFG_ADDR_NVM];
      main_protect_bit      = r_ff.cfg[TAMAL_CFG_MAIN_PROT];
      aux_protect_bit       = r_ff.cfg[TAMAL_CFG_AUX_PROT];
      // Pin idles high, so protection rests on the bit alone until grounded
      main_locked = r_ff.prot_f & main_protect_bit;
      aux_locked  = aux_protect_bit;
      main_addr   = main_address_from_nvm ? r_ff.nvm_addr : TAMAL_MAIN_ADDR;

      // Map the current pointer onto a storage kind and block
      kind   = TAMAL_K_NONE;
      blk    = TAMAL_BLK_MAIN;
      locked = 1'b1;
      if (!r_ff.dev_main) begin
         if (r_ff.ptr < TAMAL_OFS_UPPER) begin
            kind   = TAMAL_K_MEM;
            blk    = TAMAL_BLK_AUX;
            locked = aux_locked;
         end
      end else if (r_ff.ptr < TAMAL_OFS_UPPER) begin
         if (r_ff.ptr >= TAMAL_OFS_MEAS_LO && r_ff.ptr <= TAMAL_OFS_MEAS_HI) begin
            kind = TAMAL_K_MEAS;
         end else if (r_ff.ptr == TAMAL_OFS_TABLE_SEL) begin
            kind   = TAMAL_K_FLOP;
            locked = 1'b0;
         end else begin
            kind   = TAMAL_K_MEM;
            locked = main_locked;
         end
      end else begin
         case (r_ff.selector)
            TAMAL_SEL_TABLE0: begin
               if (single_address_select) begin
                  kind   = TAMAL_K_MEM;
                  blk    = TAMAL_BLK_TABLE0;
                  locked = aux_locked;
               end
            end
            TAMAL_SEL_TABLE1: begin
               locked = main_locked;
               blk    = TAMAL_BLK_TABLE1;
               if (r_ff.ptr == TAMAL_OFS_MANUAL_ZERO || r_ff.ptr == TAMAL_OFS_MANUAL_ONE ||
                   r_ff.ptr == TAMAL_OFS_CONFIG || r_ff.ptr == TAMAL_OFS_STORED_ADDR) begin
                  kind = TAMAL_K_FLOP;
               end else begin
                  kind = TAMAL_K_MEM;
               end
            end
            TAMAL_SEL_LUT0: begin
               kind   = TAMAL_K_MEM;
               blk    = TAMAL_BLK_LUT0;
               locked = main_locked;
            end
            TAMAL_SEL_LUT1: begin
               kind   = TAMAL_K_MEM;
               blk    = TAMAL_BLK_LUT1;
               locked = main_locked;
            end
            TAMAL_SEL_AUX: begin
               kind   = TAMAL_K_MEM;
               blk    = TAMAL_BLK_AUX;
               locked = aux_locked;
            end
            default: begin
               kind = TAMAL_K_NONE;
            end
         endcase
      end
      mem_raddr_a = {blk, r_ff.ptr[6:0]};

      // Measured words, most significant byte at the even location
      case (r_ff.ptr[3:1])
         3'h0:    meas_word = meas_in.temp;
         3'h1:    meas_word = meas_in.vcc;
         3'h2:    meas_word = meas_in.mon_a;
         3'h3:    meas_word = meas_in.mon_b;
         3'h4:    meas_word = meas_in.mon_c;
         default: meas_word = 16'h0000;
      endcase

      case (kind)
         TAMAL_K_MEM:  rd_val = mem_rdata_a;
         TAMAL_K_MEAS: rd_val = r_ff.ptr[0] ? meas_word[7:0] : meas_word[15:8];
         TAMAL_K_FLOP: begin
            case (r_ff.ptr)
               TAMAL_OFS_TABLE_SEL:   rd_val = r_ff.selector;
               TAMAL_OFS_MANUAL_ZERO: rd_val = r_ff.manual_zero;
               TAMAL_OFS_MANUAL_ONE:  rd_val = r_ff.manual_one;
               TAMAL_OFS_CONFIG:      rd_val = r_ff.cfg;
               default:               rd_val = r_ff.nvm_addr;
            endcase
         end
         default: rd_val = TAMAL_UNMAPPED_READ;
      endcase

      match_aux  = !single_address_select &&
                   (r_ff.shift[7:1] == TAMAL_AUX_ADDR[7:1]);
      match_main = (r_ff.shift[7:1] == main_addr[7:1]);

      if (bus_start) begin
         nxt_r.state  = TAMAL_DEV;
         nxt_r.bitcnt = 4'h0;
         nxt_r.sda_oe = 1'b0;
      end else if (bus_stop) begin
         nxt_r.state  = TAMAL_IDLE;
         nxt_r.sda_oe = 1'b0;
      end else begin
         case (r_ff.state)
            TAMAL_DEV, TAMAL_WADDR, TAMAL_WDATA: begin
               if (scl_rise && r_ff.bitcnt < TAMAL_BITS_PER_BYTE) begin
                  nxt_r.shift  = {r_ff.shift[6:0], nxt_r.sda_f};
                  nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
               end else if (scl_fall && r_ff.bitcnt == TAMAL_BITS_PER_BYTE) begin
                  nxt_r.bitcnt = 4'h0;
                  nxt_r.sda_oe = 1'b1;
                  nxt_r.state  = TAMAL_ACK;
                  nxt_r.after  = TAMAL_WDATA;
                  if (r_ff.state == TAMAL_DEV) begin
                     nxt_r.dev_main = match_main;
                     nxt_r.after    = r_ff.shift[0] ? TAMAL_RD : TAMAL_WADDR;
                     if (!match_aux && !match_main) begin
                        nxt_r.sda_oe = 1'b0;
                        nxt_r.state  = TAMAL_IDLE;
                     end
                  end else if (r_ff.state == TAMAL_WADDR) begin
                     nxt_r.ptr = r_ff.shift;
                  end else begin
                     nxt_r.ptr = r_ff.ptr + 8'h01;
                     if (kind == TAMAL_K_MEM && !locked) begin
                        nxt_r.we    = 1'b1;
                        nxt_r.waddr = mem_raddr_a;
                        nxt_r.wdata = r_ff.shift;
                     end else if (kind == TAMAL_K_FLOP && !locked) begin
                        case (r_ff.ptr)
                           TAMAL_OFS_TABLE_SEL:   nxt_r.selector    = r_ff.shift;
                           TAMAL_OFS_MANUAL_ZERO: nxt_r.manual_zero = r_ff.shift;
                           TAMAL_OFS_MANUAL_ONE:  nxt_r.manual_one  = r_ff.shift;
                           TAMAL_OFS_CONFIG:      nxt_r.cfg         = r_ff.shift;
                           default:               nxt_r.nvm_addr    = r_ff.shift;
                        endcase
                     end
                  end
               end
            end
            TAMAL_ACK: begin
               if (scl_fall) begin
                  nxt_r.sda_oe = 1'b0;
                  nxt_r.state  = r_ff.after;
                  if (r_ff.after == TAMAL_RD) begin
                     nxt_r.shift  = rd_val;
                     nxt_r.sda_oe = ~rd_val[7];
                     nxt_r.bitcnt = 4'h1;
                  end
               end
            end
            TAMAL_RD: begin
               if (scl_fall) begin
                  if (r_ff.bitcnt == TAMAL_BITS_PER_BYTE) begin
                     nxt_r.sda_oe = 1'b0;
                     nxt_r.state  = TAMAL_RACK;
                  end else begin
                     nxt_r.shift  = {r_ff.shift[6:0], 1'b0};
                     nxt_r.sda_oe = ~r_ff.shift[6];
                     nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                  end
               end
            end
            TAMAL_RACK: begin
               // Pointer moves at the rise so the read data settle before the fall
               if (scl_rise) begin
                  if (!nxt_r.sda_f) begin
                     nxt_r.ptr   = r_ff.ptr + 8'h01;
                     nxt_r.state = TAMAL_RLOAD;
                  end else begin
                     nxt_r.state = TAMAL_IDLE;
                  end
               end
            end
            TAMAL_RLOAD: begin
               if (scl_fall) begin
                  nxt_r.shift  = rd_val;
                  nxt_r.sda_oe = ~rd_val[7];
                  nxt_r.bitcnt = 4'h1;
                  nxt_r.state  = TAMAL_RD;
               end
            end
            default: begin
               nxt_r.sda_oe = 1'b0;
            end
         endcase
      end

      // Alternate look-up reads between the two resistor tables
      nxt_r.lut_phase   = ~r_ff.lut_phase;
      nxt_r.lut_phase_d = r_ff.lut_phase;
      mem_raddr_b = {(r_ff.lut_phase ? TAMAL_BLK_LUT1 : TAMAL_BLK_LUT0), lut_index};
      if (r_ff.lut_phase_d) begin
         nxt_r.lut_one = mem_rdata_b;
      end else begin
         nxt_r.lut_zero = mem_rdata_b;
      end
      if (temp_index_enable) begin
         nxt_r.pos.zero = r_ff.lut_zero;
         nxt_r.pos.one  = r_ff.lut_one;
      end else begin
         nxt_r.pos.zero = r_ff.manual_zero;
         nxt_r.pos.one  = r_ff.manual_one;
      end

      if (rst_in) begin
         nxt_r          = '0;
         nxt_r.scl_s    = 3'h7;
         nxt_r.sda_s    = 3'h7;
         nxt_r.prot_s   = 3'h7;
         nxt_r.scl_f    = 1'b1;
         nxt_r.sda_f    = 1'b1;
         nxt_r.prot_f   = 1'b1;
         nxt_r.state    = TAMAL_IDLE;
         nxt_r.after    = TAMAL_IDLE;
         nxt_r.selector = TAMAL_SEL_RESET;
         nxt_r.cfg      = TAMAL_CFG_RESET;
         nxt_r.nvm_addr = TAMAL_NVM_ADDR_RESET;
      end
      nxt_r.manual = ~nxt_r.cfg[TAMAL_CFG_TEMP_INDEX];
   end

   always_ff @(posedge clk_in) begin
      r_ff <= nxt_r;
   end

   assign sda_out         = 1'b0;
   assign sda_oe_out      = r_ff.sda_oe;
   assign pos_out         = r_ff.pos;
   assign manual_mode_out = r_ff.manual;

endmodule : tamal_access_top
`default_nettype wire

// ### tamal_access_asserts.sv
// Checker for the memory access block: bus answer timing, reset state, positions.
// Bound to tamal_access_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module tamal_access_asserts
   import tamal_pkg::*;
(
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   // Bus and protect pins
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe_out,
   input wire logic        protect_pin_in,
   // Data
   input wire tamal_meas_t meas_in,
   input wire tamal_pos_t  pos_out,
   input wire logic        manual_mode_out
);
   logic [4:0] fall_ff;
   logic [3:0] run_ff;
   default clocking cb @(posedge clk_in); endclocking
   // Ages since the last bus clock fall and since reset, saturating
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fall_ff <= 5'h1F;
         run_ff  <= 4'h0;
      end else begin
         fall_ff <= $fell(scl_in) ? 5'h00 : fall_ff + {4'h0, fall_ff != 5'h1F};
         run_ff  <= run_ff + {3'h0, run_ff != 4'hF};
      end
   end
   // Quiet bus clock high phase; look-up memory may hold unknowns, hence ===
   sequence quiet_man;
      (manual_mode_out && scl_in && $stable(sda_in) && run_ff == 4'hF)[*8];
   endsequence
   sequence quiet_lut;
      (!manual_mode_out && scl_in && $stable(sda_in) && $stable(meas_in)
       && run_ff == 4'hF)[*8];
   endsequence
   sda_low_a: assert property (sda_out == 1'b0)
      else $error("sda value not low");
   rst_bus_a: assert property (rst_in |=> !sda_oe_out)
      else $error("bus driven after reset");
   rst_out_a: assert property (rst_in |=> !manual_mode_out && pos_out == '0)
      else $error("outputs not cleared by reset");
   oe_edge_a: assert property (disable iff (rst_in)
      $changed(sda_oe_out) |-> fall_ff inside {[5'd1:5'd8]})
      else $error("sda drive changed away from a clock fall");
   oe_steady_a: assert property (disable iff (rst_in)
      scl_in[*5] |-> $stable(sda_oe_out))
      else $error("sda drive changed in clock high phase");
   mode_edge_a: assert property (disable iff (rst_in)
      $changed(manual_mode_out) |-> fall_ff inside {[5'd1:5'd28]})
      else $error("manual mode changed without a bus write");
   man_hold_a: assert property (disable iff (rst_in)
      quiet_man |=> pos_out === $past(pos_out))
      else $error("manual position moved without a write");
   lut_hold_a: assert property (disable iff (rst_in)
      quiet_lut |=> pos_out === $past(pos_out))
      else $error("indexed position moved at steady temperature");
endmodule : tamal_access_asserts
bind tamal_access_top tamal_access_asserts u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .protect_pin_in(protect_pin_in),
   .meas_in(meas_in), .pos_out(pos_out), .manual_mode_out(manual_mode_out)
);
`default_nettype wire

// ### tamal_host_model.sv
// Two-wire bus host model with open-drain data line and pull-up.
// Assumes the device pulls the line low through dev_oe_in.
`timescale 1ns/1ps
`default_nettype none
module tamal_host_model (
   // Clock
   input  wire logic clk_in,
   // Device pull-down
   input  wire logic dev_oe_in,
   // Bus wires
   output logic      scl_out,
   output logic      sda_out
);
   logic pull_low = 1'b0;
   initial scl_out = 1'b1;
   // Released line floats to the pull-up level
   assign sda_out = !(pull_low || dev_oe_in);
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick
   // Data moves 3 clocks after the fall, so it never races the clock edge
   task automatic bit_cyc(input logic v, input logic mid, output logic s);
      pull_low = !v;
      tick(7);
      scl_out = 1'b1;
      tick(5);
      s = sda_out;
      if (mid) pull_low = 1'b1;
      tick(5);
      scl_out = 1'b0;
      tick(3);
   endtask : bit_cyc
   task automatic bus_start();
      logic s;
      bit_cyc(1'b1, 1'b1, s);
   endtask : bus_start
   task automatic bus_stop();
      pull_low = 1'b1;
      tick(7);
      scl_out = 1'b1;
      tick(5);
      pull_low = 1'b0;
      tick(10);
   endtask : bus_stop
   task automatic put(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(b[i], 1'b0, s);
      bit_cyc(1'b1, 1'b0, s);
      ack = !s;
   endtask : put
   task automatic get(output logic [7:0] b, input logic more);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(1'b1, 1'b0, b[i]);
      bit_cyc(!more, 1'b0, s);
   endtask : get
endmodule : tamal_host_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench: host model reaches the access block over the two-wire bus.
// Protect pin starts high as its pull-up would hold it.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import tamal_pkg::*;
;
   logic        clk;
   logic        rst;
   logic        prot;
   tamal_meas_t meas;
   tamal_pos_t  pos;
   logic        manual;
   logic        oe;
   logic        sda_val;
   logic        scl;
   logic        sda;
   logic [7:0]  d;
   logic [87:0] mv;
   int          num_errors = 0;
   int          n_checks = 0;
   logic [7:0]  tt [5] = '{8'hCE, 8'hD9, 8'hDA, 8'h66, 8'h7F};
   logic [15:0] te [5] = '{16'h1144, 16'h1144, 16'h3366, 16'h2255, 16'h2255};
   logic [7:0]  lo [6] = '{8'h80, 8'h81, 8'hC7, 8'h80, 8'h81, 8'hC7};
   logic [7:0]  lv [6] = '{8'h11, 8'h33, 8'h22, 8'h44, 8'h66, 8'h55};
   tamal_access_top dut (
      .clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_val),
      .sda_oe_out(oe), .protect_pin_in(prot), .meas_in(meas), .pos_out(pos),
      .manual_mode_out(manual)
   );
   tamal_host_model host (.clk_in(clk), .dev_oe_in(oe), .scl_out(scl), .sda_out(sda));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] dv, input logic [7:0] p, input logic [7:0] v,
                     input logic ea);
      logic [2:0] a;
      host.bus_start();
      host.put(dv, a[2]);
      host.put(p, a[1]);
      host.put(v, a[0]);
      host.bus_stop();
      chk("write ack", {13'h0, {3{ea}}}, {13'h0, a});
   endtask : wr
   // Pointer write, repeated start, one byte read with host nack
   task automatic rdc(input logic [7:0] dv, input logic [7:0] p, input logic ea,
                      input logic [7:0] e);
      logic [2:0] a;
      host.bus_start();
      host.put(dv, a[2]);
      host.put(p, a[1]);
      host.bus_start();
      host.put(dv | 8'h01, a[0]);
      host.get(d, 1'b0);
      host.bus_stop();
      chk("read ack", {13'h0, {3{ea}}}, {13'h0, a});
      chk("read data", {8'h00, e}, {8'h00, d});
   endtask : rdc
   task automatic wait_pos(input logic [15:0] e);
      for (int i = 0; i < 50 && pos !== e; i++) host.tick(1);
      chk("position", e, pos);
   endtask : wait_pos
   task automatic rdm();
      host.bus_start();
      host.put(8'hA2, d[0]);
      host.put(8'h60, d[0]);
      host.bus_start();
      host.put(8'hA3, d[0]);
      for (int k = 0; k < 11; k++) begin
         host.get(d, k < 10);
         chk("burst", {8'h00, mv[87 - 8*k -: 8]}, {8'h00, d});
      end
      host.bus_stop();
   endtask : rdm
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      rst = 1'b1;
      prot = 1'b1;
      meas = '0;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      host.tick(4);
      chk("manual", 16'h0, {15'h0, manual});
      rdc(8'hA2, 8'h7F, 1'b1, 8'h00);
      wr(8'hA2, 8'h7F, 8'h01, 1'b1);
      rdc(8'hA2, 8'h8C, 1'b1, 8'hA2);
      wr(8'hA2, 8'h82, 8'h5A, 1'b1);
      wr(8'hA2, 8'h83, 8'hC3, 1'b1);
      wr(8'hA2, 8'h89, 8'h00, 1'b1);
      chk("manual", 16'h1, {15'h0, manual});
      meas.temp = 16'h1900;
      host.tick(20);
      chk("position", 16'h5AC3, pos);
      for (int i = 0; i < 6; i++) begin
         if (i % 3 == 0) wr(8'hA2, 8'h7F, (i == 0) ? 8'h02 : 8'h03, 1'b1);
         wr(8'hA2, lo[i], lv[i], 1'b1);
      end
      rdc(8'hA2, 8'h80, 1'b1, 8'h44);
      wr(8'hA2, 8'h7F, 8'h01, 1'b1);
      wr(8'hA2, 8'h89, 8'h01, 1'b1);
      for (int i = 0; i < 5; i++) begin
         meas.temp = {tt[i], 8'h80};
         wait_pos(te[i]);
      end
      meas = {16'hF680, 16'h80F8, 16'hC000, 16'h8080, 16'h1234};
      mv = {meas, 8'h00};
      for (int k = 0; k < 11; k++) begin
         rdc(8'hA2, 8'h60 + 8'(k), 1'b1, mv[87 - 8*k -: 8]);
      end
      rdm();
      wr(8'hA2, 8'h89, 8'h08, 1'b1);
      wr(8'hA2, 8'h82, 8'hAA, 1'b1);
      rdc(8'hA2, 8'h82, 1'b1, 8'h5A);
      prot = 1'b0;
      wr(8'hA2, 8'h82, 8'hAA, 1'b1);
      rdc(8'hA2, 8'h82, 1'b1, 8'hAA);
      chk("position", 16'hAAC3, pos);
      wr(8'hA0, 8'h10, 8'h77, 1'b1);
      wr(8'hA2, 8'h89, 8'h10, 1'b1);
      wr(8'hA0, 8'h10, 8'h55, 1'b1);
      rdc(8'hA0, 8'h10, 1'b1, 8'h77);
      rdc(8'hA0, 8'h90, 1'b1, 8'hFF);
      wr(8'hA2, 8'h8C, 8'hB4, 1'b1);
      wr(8'hA2, 8'h89, 8'h04, 1'b1);
      rdc(8'hA2, 8'h7F, 1'b0, 8'hFF);
      rdc(8'hB4, 8'h7F, 1'b1, 8'h01);
      wr(8'hB4, 8'h89, 8'h06, 1'b1);
      rdc(8'hA0, 8'h10, 1'b0, 8'hFF);
      wr(8'hB4, 8'h7F, 8'h00, 1'b1);
      wr(8'hB4, 8'h90, 8'h3C, 1'b1);
      rdc(8'hB4, 8'h90, 1'b1, 8'h3C);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
